//--- pkg/maces_map.svh
// register offsets, field positions, reset values and counts of the mac error/address bank
`ifndef MACES_MAP_SVH
`define MACES_MAP_SVH
`define MACES_ADDR_W 12
`define MACES_OFF_SEED 12'h110
`define MACES_OFF_ERR 12'h114
`define MACES_OFF_ADDRH 12'h118
`define MACES_OFF_ADDRL 12'h11c
`define MACES_SEED_RESET 16'h9876
`define MACES_ADDRH_RESET 16'hffff
`define MACES_ADDRL_RESET 32'hffffffff
`define MACES_ERR_LSB 2
`define MACES_ERR_MSB 9
`define MACES_BIT_UNDERRUN 0
`define MACES_BIT_ALIGN 1
`define MACES_BIT_COLLIDE 2
`define MACES_BIT_WDOG 3
`define MACES_BIT_RUNT 4
`define MACES_BIT_LONG 5
`define MACES_BIT_CRC 6
`define MACES_BIT_PHYERR 7
`define MACES_WDOG_BYTES 14'd11264
`endif

//--- pkg/maces_pkg.sv
// types shared by the mac error status and station address bank
`default_nettype none
package maces_pkg;
  typedef struct packed {
    logic frame_active;
    logic byte_valid;
    logic phy_receive_fault;
    logic checksum_bad;
    logic oversize;
    logic undersize;
    logic alignment_fault;
  } maces_rx_event_t;
  typedef struct packed {
    logic collision_limit;
    logic underrun;
  } maces_tx_event_t;
  typedef struct packed {
    logic load;
    logic present;
    logic [47:0] address;
  } maces_image_t;
  typedef struct packed {
    logic [15:0] seed;
    logic [15:0] lfsr;
    logic [7:0] flags;
    logic [15:0] addr_high;
    logic [31:0] addr_low;
    logic [15:0] image_high;
    logic [31:0] image_low;
    logic image_loaded;
    logic [13:0] byte_count;
    logic truncate;
    logic match;
    logic [31:0] read_data;
  } maces_state_t;
endpackage
`default_nettype wire

//--- logic/maces_regs.sv
// mac back-off seed, sticky error flags and station address register bank
// Operation
// [R01] 16-bit seed, reset 9876h, loads the back-off random shift register
// [R02] phy receive error during a frame sets error bit 9
// [R03] received frame with bad checksum sets error bit 8
// [R04] frame over the maximum size sets error bit 7
// [R05] runt or short frame sets error bit 6
// [R06] frames over 11,264 bytes are truncated and set error bit 5
// [R07] abort after sixteen collisions sets error bit 4
// [R08] alignment error on a received frame sets error bit 3
// [R09] transmit underrun sets error bit 2
// [R10] error flags stay set until software clears them; reserved bits read zero
// [R11] address high bits 15:0 hold 47:32, low register holds 31:0
// [R12] octets in reception order: low 7:0 first, high 15:8 sixth
// [R13] stored address compared for destination match, wake and pause detection
// [R14] stored address is the source address of transmitted pause frames
// [R15] stored address takes no part in general receive filtering
// [R16] address starts from eeprom, else otp, else all ones
// [R17] usb reset restores low word from image, else all ones
// [R18] usb reset restores high field from image, else keeps it
// [R19] shift register advances each clock and reloads on seed write
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "maces_map.svh"

module maces_regs
  import maces_pkg::*;
(
  // clock, reset, enable
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // register port
  input wire logic [`MACES_ADDR_W-1:0] reg_address,
  input wire logic [31:0] reg_write_data,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_read_data,
  // mac datapath events
  input wire maces_rx_event_t rx_event,
  input wire maces_tx_event_t tx_event,
  output logic rx_truncate,
  // destination compare
  input wire logic rx_dest_valid,
  input wire logic [47:0] rx_dest_address,
  output logic station_match,
  // address users and back-off
  output logic [47:0] station_address,
  output logic [15:0] backoff_random,
  // configuration image and usb reset
  input wire maces_image_t image,
  input wire logic usb_reset
);

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [`MACES_ADDR_W-1:0] a,
                               input logic [`MACES_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    logic fb;
    fb = v[15] ^ v[13] ^ v[12] ^ v[10];
    // an all-zero seed would lock the generator, so force a one in
    lfsr_step = {v[14:0], fb | (v == 16'h0000)};
  endfunction

  // ==========================================================
  // state
  maces_state_t state;
  maces_state_t next_state;
  logic [7:0] set_flags;
  logic [7:0] clear_flags;
  logic seed_write;
  logic wdog_hit;

  always_comb begin
    set_flags = 8'h00;
    set_flags[`MACES_BIT_PHYERR] = rx_event.frame_active
                                   & rx_event.phy_receive_fault; // see [R02]
    set_flags[`MACES_BIT_CRC] = rx_event.checksum_bad; // see [R03]
    set_flags[`MACES_BIT_LONG] = rx_event.oversize; // see [R04]
    set_flags[`MACES_BIT_RUNT] = rx_event.undersize; // see [R05]
    set_flags[`MACES_BIT_WDOG] = wdog_hit; // see [R06]
    set_flags[`MACES_BIT_COLLIDE] = tx_event.collision_limit; // see [R07]
    set_flags[`MACES_BIT_ALIGN] = rx_event.alignment_fault; // see [R08]
    set_flags[`MACES_BIT_UNDERRUN] = tx_event.underrun; // see [R09]
  end

  assign seed_write = reg_write & hit(reg_address, `MACES_OFF_SEED);
  // the byte past the limit is the one that gets cut
  assign wdog_hit = rx_event.frame_active & rx_event.byte_valid & ~state.truncate
                    & (state.byte_count == `MACES_WDOG_BYTES);

  always_comb begin
    clear_flags = 8'h00;
    if (reg_write && hit(reg_address, `MACES_OFF_ERR)) begin
      clear_flags = reg_write_data[`MACES_ERR_MSB:`MACES_ERR_LSB];
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    if (clock_enable) begin
      // seed and generator
      if (seed_write) begin
        next_state.seed = reg_write_data[15:0]; // see [R01]
        next_state.lfsr = reg_write_data[15:0]; // see [R19]
      end else begin
        next_state.lfsr = lfsr_step(state.lfsr); // see [R19]
      end

      // set wins over a clear in the same cycle
      next_state.flags = (state.flags & ~clear_flags) | set_flags; // see [R10]

      // receive watchdog
      if (!rx_event.frame_active) begin
        next_state.byte_count = 14'd0;
        next_state.truncate = 1'b0;
      end else if (wdog_hit) begin
        next_state.truncate = 1'b1; // see [R06]
      end else if (rx_event.byte_valid && !state.truncate) begin
        next_state.byte_count = state.byte_count + 14'd1;
      end

      // image capture
      if (image.load) begin
        next_state.image_loaded = image.present;
        if (image.present) begin
          next_state.image_high = image.address[47:32];
          next_state.image_low = image.address[31:0];
          next_state.addr_high = image.address[47:32]; // see [R16]
          next_state.addr_low = image.address[31:0]; // see [R16]
        end else begin
          next_state.addr_high = `MACES_ADDRH_RESET; // see [R16]
          next_state.addr_low = `MACES_ADDRL_RESET; // see [R16]
        end
      end else if (usb_reset) begin
        if (state.image_loaded) begin
          next_state.addr_low = state.image_low; // see [R17]
          next_state.addr_high = state.image_high; // see [R18]
        end else begin
          next_state.addr_low = `MACES_ADDRL_RESET; // see [R17]
        end
      end else if (reg_write) begin
        if (hit(reg_address, `MACES_OFF_ADDRH)) begin
          next_state.addr_high = reg_write_data[15:0]; // see [R11]
        end
        if (hit(reg_address, `MACES_OFF_ADDRL)) begin
          next_state.addr_low = reg_write_data; // see [R11]
        end
      end

      // destination compare, octet one in bits 7:0
      next_state.match = rx_dest_valid
        & (rx_dest_address == {state.addr_high, state.addr_low}); // see [R13] see [R12]

      // read data for one cycle only
      next_state.read_data = 32'h00000000;
      if (reg_read) begin
        if (hit(reg_address, `MACES_OFF_SEED)) begin
          next_state.read_data = {16'h0000, state.seed};
        end else if (hit(reg_address, `MACES_OFF_ERR)) begin
          next_state.read_data = {22'h000000, state.flags, 2'b00}; // see [R10]
        end else if (hit(reg_address, `MACES_OFF_ADDRH)) begin
          next_state.read_data = {16'h0000, state.addr_high};
        end else if (hit(reg_address, `MACES_OFF_ADDRL)) begin
          next_state.read_data = state.addr_low;
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
      state.seed <= `MACES_SEED_RESET; // see [R01]
      state.lfsr <= `MACES_SEED_RESET; // see [R01]
      state.addr_high <= `MACES_ADDRH_RESET;
      state.addr_low <= `MACES_ADDRL_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign reg_read_data = state.read_data;
  assign rx_truncate = state.truncate;
  assign station_match = state.match;
  // filtering logic gets no copy of the address; only wake and pause users do
  assign station_address = {state.addr_high, state.addr_low}; // see [R14] see [R15]
  assign backoff_random = state.lfsr;

  // ==========================================================
  // checks
  sequence s_seed_write;
    clock_enable && seed_write;
  endsequence

  sequence s_wdog_limit;
    clock_enable && wdog_hit;
  endsequence

  sequence s_image_present;
    clock_enable && image.load && image.present;
  endsequence

  sequence s_usb_restore;
    clock_enable && usb_reset && !image.load && state.image_loaded;
  endsequence

  sequence s_flag_clear;
    clock_enable && (clear_flags & ~set_flags) != 8'h00;
  endsequence

  a_seed_reset: assert property (@(posedge clock)
    $fell(reset) |-> state.seed == `MACES_SEED_RESET) // see [R01]
    else $error("seed not at reset value");

  a_seed_reload: assert property (@(posedge clock) disable iff (reset)
    s_seed_write |=> backoff_random == $past(reg_write_data[15:0])) // see [R19]
    else $error("shift register not reloaded");

  a_lfsr_moves: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !seed_write |=> backoff_random == lfsr_step($past(state.lfsr))) // see [R19]
    else $error("shift register did not step");

  a_phy_fault: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_event.frame_active && rx_event.phy_receive_fault
    |=> state.flags[`MACES_BIT_PHYERR]) // see [R02]
    else $error("phy fault flag not set");

  a_crc_flag: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_event.checksum_bad |=> state.flags[`MACES_BIT_CRC]) // see [R03]
    else $error("checksum flag not set");

  a_long_flag: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_event.oversize |=> state.flags[`MACES_BIT_LONG]) // see [R04]
    else $error("oversize flag not set");

  a_runt_flag: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_event.undersize |=> state.flags[`MACES_BIT_RUNT]) // see [R05]
    else $error("undersize flag not set");

  a_wdog_cut: assert property (@(posedge clock) disable iff (reset)
    s_wdog_limit |=> rx_truncate && state.flags[`MACES_BIT_WDOG]) // see [R06]
    else $error("watchdog did not truncate");

  a_collide_flag: assert property (@(posedge clock) disable iff (reset)
    clock_enable && tx_event.collision_limit |=> state.flags[`MACES_BIT_COLLIDE]) // see [R07]
    else $error("collision flag not set");

  a_align_flag: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_event.alignment_fault |=> state.flags[`MACES_BIT_ALIGN]) // see [R08]
    else $error("alignment flag not set");

  a_underrun_flag: assert property (@(posedge clock) disable iff (reset)
    clock_enable && tx_event.underrun |=> state.flags[`MACES_BIT_UNDERRUN]) // see [R09]
    else $error("underrun flag not set");

  a_flag_sticky: assert property (@(posedge clock) disable iff (reset)
    clock_enable && clear_flags == 8'h00 |=> (state.flags & $past(state.flags)) == $past(state.flags)) // see [R10]
    else $error("flag lost without a clear");

  a_read_low: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_read && hit(reg_address, `MACES_OFF_ADDRL)
    |=> reg_read_data == $past(station_address[31:0]) ##1 reg_read_data == 32'h0 || $past(reg_read)) // see [R11]
    else $error("low address read wrong");

  a_match_dest: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_dest_valid && rx_dest_address == station_address
    && !image.load && !usb_reset && !reg_write |=> station_match) // see [R13]
    else $error("destination match missed");

  a_usb_low: assert property (@(posedge clock) disable iff (reset)
    clock_enable && usb_reset && !image.load && !state.image_loaded
    |=> station_address[31:0] == `MACES_ADDRL_RESET) // see [R17]
    else $error("low word not restored");

  a_usb_high: assert property (@(posedge clock) disable iff (reset)
    clock_enable && usb_reset && !image.load && !state.image_loaded
    |=> station_address[47:32] == $past(station_address[47:32])) // see [R18]
    else $error("high field changed without image");

  a_usb_restore: assert property (@(posedge clock) disable iff (reset)
    s_usb_restore |=> station_address == $past({state.image_high, state.image_low})) // see [R17] see [R18]
    else $error("image not restored on usb reset");

  a_freeze_state: assert property (@(posedge clock) disable iff (reset)
    !clock_enable |=> state == $past(state))
    else $error("state moved while clock enable low");

  a_seed_hold: assert property (@(posedge clock) disable iff (reset)
    !seed_write |=> state.seed == $past(state.seed)) // see [R01]
    else $error("seed changed without a write");

  a_seed_read: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_read && hit(reg_address, `MACES_OFF_SEED)
    |=> reg_read_data == {16'h0000, $past(state.seed)}) // see [R01]
    else $error("seed read wrong");

  a_lfsr_nonzero: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !seed_write |=> backoff_random != 16'h0000) // see [R19]
    else $error("shift register stuck at zero");

  a_phy_outside: assert property (@(posedge clock) disable iff (reset)
    !rx_event.frame_active && !state.flags[`MACES_BIT_PHYERR]
    |=> !state.flags[`MACES_BIT_PHYERR]) // see [R02]
    else $error("phy fault flag set outside a frame");

  a_flag_clear: assert property (@(posedge clock) disable iff (reset)
    s_flag_clear |=> (state.flags & $past(clear_flags & ~set_flags)) == 8'h00) // see [R10]
    else $error("flag not cleared by write");

  a_set_wins: assert property (@(posedge clock) disable iff (reset)
    clock_enable && (set_flags & clear_flags) != 8'h00
    |=> (state.flags & $past(set_flags)) == $past(set_flags)) // see [R10]
    else $error("clear beat a set in the same cycle");

  a_err_read: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_read && hit(reg_address, `MACES_OFF_ERR)
    |=> reg_read_data == {22'h0, $past(state.flags), 2'b00}) // see [R10]
    else $error("error read wrong or reserved bits set");

  a_read_high: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_read && hit(reg_address, `MACES_OFF_ADDRH)
    |=> reg_read_data == {16'h0000, $past(station_address[47:32])}) // see [R11]
    else $error("high address read wrong");

  // read data must drop back so a stale word is never taken for a new read
  a_read_idle: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !reg_read |=> reg_read_data == 32'h00000000)
    else $error("read data not cleared");

  a_write_high: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_write && hit(reg_address, `MACES_OFF_ADDRH) && !image.load && !usb_reset
    |=> station_address[47:32] == $past(reg_write_data[15:0])) // see [R11]
    else $error("high address write lost");

  a_write_low: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_write && hit(reg_address, `MACES_OFF_ADDRL) && !image.load && !usb_reset
    |=> station_address[31:0] == $past(reg_write_data)) // see [R11] see [R12]
    else $error("low address write lost");

  a_image_load: assert property (@(posedge clock) disable iff (reset)
    s_image_present |=> station_address == $past(image.address)) // see [R16]
    else $error("image address not loaded");

  a_image_absent: assert property (@(posedge clock) disable iff (reset)
    clock_enable && image.load && !image.present
    |=> station_address == {`MACES_ADDRH_RESET, `MACES_ADDRL_RESET}) // see [R16]
    else $error("address not all ones without image");

  a_match_miss: assert property (@(posedge clock) disable iff (reset)
    clock_enable && (!rx_dest_valid || rx_dest_address != station_address) |=> !station_match) // see [R13]
    else $error("false destination match");

  a_trunc_hold: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_truncate && rx_event.frame_active |=> rx_truncate) // see [R06]
    else $error("truncation dropped inside a frame");

  a_trunc_clear: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !rx_event.frame_active |=> !rx_truncate && state.byte_count == 14'd0) // see [R06]
    else $error("watchdog not cleared after frame");

  a_count_bound: assert property (@(posedge clock) disable iff (reset)
    state.byte_count <= `MACES_WDOG_BYTES) // see [R06]
    else $error("byte count past the limit");

endmodule

`default_nettype wire

//--- sim/maces_regs_tb.sv
// self-checking bench for the mac error status and station address bank
`timescale 1ns/10ps
`default_nettype none
`include "maces_map.svh"

module tb;
  import maces_pkg::*;
  // ==========================================
  // signals
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clock_enable = 1'b1;
  logic [11:0] reg_address = 12'h000;
  logic [31:0] reg_write_data = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_read_data;
  maces_rx_event_t rx_event = '0;
  maces_tx_event_t tx_event = '0;
  logic rx_truncate;
  logic rx_dest_valid = 1'b0;
  logic [47:0] rx_dest_address = 48'h0;
  logic station_match;
  logic [47:0] station_address;
  logic [15:0] backoff_random;
  maces_image_t image = '0;
  logic usb_reset = 1'b0;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] q[$];
  logic pend = 1'b0;
  logic [47:0] a, b;
  logic [15:0] r0;
  logic [8:0] ev [9] = '{9'h140, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001, 9'h040, 9'h080};
  logic [31:0] ex [9] = '{32'h200, 32'h100, 32'h80, 32'h40, 32'h8, 32'h10, 32'h4, 32'h0, 32'h0};

  always #25 clock = ~clock;

  maces_regs maces_regs_inst (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .reg_address(reg_address), .reg_write_data(reg_write_data), .reg_write(reg_write),
    .reg_read(reg_read), .reg_read_data(reg_read_data), .rx_event(rx_event), .tx_event(tx_event),
    .rx_truncate(rx_truncate), .rx_dest_valid(rx_dest_valid), .rx_dest_address(rx_dest_address),
    .station_match(station_match), .station_address(station_address),
    .backoff_random(backoff_random), .image(image), .usb_reset(usb_reset));

  // ==========================================
  // compare, bus and closing tasks
  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    reg_address <= ad;
    reg_write_data <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // expected read data is queued here and compared by the monitor
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    q.push_back(e);
    @(posedge clock);
    reg_address <= ad;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask

  task automatic drive(input logic [8:0] v);
    @(posedge clock);
    {rx_event, tx_event} <= v;
    @(posedge clock);
    {rx_event, tx_event} <= 9'h0;
  endtask

  // frame of n bytes, one byte every cycle
  task automatic frame(input int n, input logic t);
    @(posedge clock);
    {rx_event, tx_event} <= 9'h180;
    repeat (n) @(posedge clock);
    {rx_event, tx_event} <= 9'h100;
    repeat (3) @(posedge clock);
    chk("rx_truncate", {47'h0, rx_truncate}, {47'h0, t});
    {rx_event, tx_event} <= 9'h0;
    repeat (2) @(posedge clock);
    rd(`MACES_OFF_ERR, t ? 32'h20 : 32'h0);
    wr(`MACES_OFF_ERR, 32'h20);
  endtask

  task automatic end_sim;
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // read data monitor: read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (pend) begin
      if (q.size() == 0) chk("queue", 48'h1, 48'h0);
      else chk("reg_read_data", {16'h0, reg_read_data}, {16'h0, q.pop_front()});
    end
    pend = reg_read;
  end

  initial begin
    #(30000 * 50);
    n_errors++;
    end_sim();
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h4fa8d550));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    // reset values and an unmapped place
    rd(`MACES_OFF_SEED, 32'h9876);
    rd(`MACES_OFF_ERR, 32'h0);
    rd(`MACES_OFF_ADDRH, 32'hffff);
    rd(`MACES_OFF_ADDRL, 32'hffffffff);
    rd(12'h120, 32'h0);
    // seed write: upper bits reserved, shift register reloads then keeps stepping
    a = {16'($urandom), $urandom};
    wr(`MACES_OFF_SEED, a[31:0]);
    #1;
    chk("backoff_reload", {32'h0, backoff_random}, {32'h0, a[15:0]});
    rd(`MACES_OFF_SEED, {16'h0, a[15:0]});
    @(posedge clock);
    r0 = backoff_random;
    @(posedge clock);
    chk("backoff_steps", {47'h0, r0 !== backoff_random}, 48'h1);
    // enable low freezes all state, an event in that time is lost
    clock_enable <= 1'b0;
    @(posedge clock);
    r0 = backoff_random;
    drive(9'h020);
    chk("freeze_lfsr", {32'h0, backoff_random}, {32'h0, r0});
    clock_enable <= 1'b1;
    rd(`MACES_OFF_ERR, 32'h0);
    // every error source but the watchdog, then write-one-to-clear; phy fault outside a frame ignored
    for (int i = 0; i < 9; i++) begin
      drive(ev[i]);
      rd(`MACES_OFF_ERR, ex[i]);
      rd(`MACES_OFF_ERR, ex[i]);
      wr(`MACES_OFF_ERR, ex[i]);
      rd(`MACES_OFF_ERR, 32'h0);
    end
    // an event beside its own clear: the event wins
    @(posedge clock);
    rx_event.checksum_bad <= 1'b1;
    reg_address <= `MACES_OFF_ERR;
    reg_write_data <= 32'h100;
    reg_write <= 1'b1;
    @(posedge clock);
    rx_event <= '0;
    reg_write <= 1'b0;
    rd(`MACES_OFF_ERR, 32'h100);
    wr(`MACES_OFF_ERR, 32'h100);
    // watchdog boundary: 11264 bytes pass, 11265 truncate
    frame(11264, 1'b0);
    frame(11265, 1'b1);
    // station address write, read back and destination compare
    a = {16'($urandom), $urandom};
    wr(`MACES_OFF_ADDRH, {a[31:16] ^ 16'h5a5a, a[47:32]});
    wr(`MACES_OFF_ADDRL, a[31:0]);
    rd(`MACES_OFF_ADDRH, {16'h0, a[47:32]});
    rd(`MACES_OFF_ADDRL, a[31:0]);
    chk("station_address", station_address, a);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      rx_dest_valid <= 1'b1;
      rx_dest_address <= a ^ {40'h0, 7'h0, k[0]};
      @(posedge clock);
      rx_dest_valid <= 1'b0;
      #1;
      chk("station_match", {47'h0, station_match}, {47'h0, k == 0});
    end
    // image load, then usb reset restores the image
    b = {16'($urandom), $urandom};
    @(posedge clock);
    image <= '{load: 1'b1, present: 1'b1, address: b};
    @(posedge clock);
    image <= '0;
    @(posedge clock);
    chk("image_load", station_address, b);
    wr(`MACES_OFF_ADDRL, a[31:0]);
    wr(`MACES_OFF_ADDRH, {16'h0, a[47:32]});
    @(posedge clock);
    usb_reset <= 1'b1;
    @(posedge clock);
    usb_reset <= 1'b0;
    @(posedge clock);
    chk("usb_restore", station_address, b);
    // no image: all ones, then usb reset keeps the high field only
    @(posedge clock);
    image <= '{load: 1'b1, present: 1'b0, address: b};
    @(posedge clock);
    image <= '0;
    @(posedge clock);
    chk("no_image", station_address, 48'hffffffffffff);
    wr(`MACES_OFF_ADDRH, {16'h0, a[47:32]});
    wr(`MACES_OFF_ADDRL, a[31:0]);
    @(posedge clock);
    usb_reset <= 1'b1;
    @(posedge clock);
    usb_reset <= 1'b0;
    rd(`MACES_OFF_ADDRL, 32'hffffffff);
    rd(`MACES_OFF_ADDRH, {16'h0, a[47:32]});
    repeat (3) @(posedge clock);
    chk("queue_empty", 48'(q.size()), 48'h0);
    end_sim();
  end
endmodule
`default_nettype wire
